// File: design/rwc_params.svh
// constants of the register-window control block: offsets, fields,
// opcodes and reset values; included by the package and the module
`ifndef RWC_PARAMS_SVH
`define RWC_PARAMS_SVH

`define RWC_WW          3
`define RWC_AW          8
`define RWC_NWIN        4'h8

`define RWC_OFF_CTRL    8'h00
`define RWC_OFF_WIN     8'h04
`define RWC_OFF_OPA_LO  8'h08
`define RWC_OFF_OPA_HI  8'h0C
`define RWC_OFF_OPB_LO  8'h10
`define RWC_OFF_OPB_HI  8'h14
`define RWC_OFF_INSTR   8'h18
`define RWC_OFF_RES_LO  8'h1C
`define RWC_OFF_RES_HI  8'h20
`define RWC_OFF_STATUS  8'h24

`define RWC_CTRL_WINDOW_TRAP_VECTOR_SELECT 0
`define RWC_CTRL_AM     8
`define RWC_CTRL_PRIV   9
`define RWC_CTRL_HPRIV  10
`define RWC_CTRL_TL     12

`define RWC_WIN_CWP     0
`define RWC_WIN_SAVE    4
`define RWC_WIN_REST    8
`define RWC_WIN_OTHER   12
`define RWC_WIN_CLEAN   16

`define RWC_ST_EVT      0
`define RWC_ST_VOTHER   3
`define RWC_ST_VNUM     4
`define RWC_ST_HCWP     8
`define RWC_ST_RD       12
`define RWC_ST_RDWE     17
`define RWC_ST_DONE     18

`define RWC_FMT3        2'h2
`define RWC_OP3_ALLOC   6'h3C
`define RWC_OP3_RETJ    6'h39
`define RWC_OP3_ACK     6'h31

`define RWC_RST_SAVE    3'h6
`define RWC_RST_CLEAN   3'h0

`endif

// File: design/rwc_pkg.sv
// types of the register-window control block
// relies on rwc_params.svh for widths
`include "rwc_params.svh"

package rwc_pkg;

  typedef enum logic [2:0] {
    RWC_IDLE = 3'b001,
    RWC_WR   = 3'b010,
    RWC_RD   = 3'b100
  } rwc_phase_type;

  typedef enum logic [2:0] {
    RWC_EV_NONE     = 3'h0,
    RWC_EV_BADENC   = 3'h1,
    RWC_EV_PRIV     = 3'h2,
    RWC_EV_MISALIGN = 3'h3,
    RWC_EV_SPILL    = 3'h4,
    RWC_EV_CLEAN    = 3'h5,
    RWC_EV_FILL     = 3'h6,
    RWC_EV_UNKNOWN  = 3'h7
  } rwc_evt_type;

  typedef struct packed {
    logic [5:0]          window_trap_vector_select;
    logic                am;
    logic                priv;
    logic                hpriv;
    logic [2:0]          tl;
  } rwc_ctrl_type;

  typedef struct packed {
    logic [`RWC_WW-1:0]  current_window_pointer;
    logic [`RWC_WW-1:0]  savable_window_count;
    logic [`RWC_WW-1:0]  restorable_window_count;
    logic [`RWC_WW-1:0]  other_space_window_count;
    logic [`RWC_WW-1:0]  clean_window_count;
  } rwc_win_type;

  typedef struct packed {
    rwc_evt_type         evt;
    logic                vother;
    logic [2:0]          vnum;
    logic [`RWC_WW-1:0]  hcwp;
    logic [4:0]          rd;
    logic                rdwe;
    logic                done;
  } rwc_stat_type;

  typedef struct packed {
    rwc_phase_type       phase;
    logic [`RWC_AW-1:0]  addr;
    rwc_ctrl_type        ctrl;
    rwc_win_type         win;
    logic [63:0]         opa;
    logic [63:0]         opb;
    logic [63:0]         res;
    rwc_stat_type        stat;
    logic [31:0]         hrdata;
    logic                hready;
    logic                hresp;
  } rwc_state_type;

endpackage

// File: design/rwc_core.sv
// register-window control: allocate, spilled-ack and return-jump
// assumes one AHB-Lite master, word transfers only, zero-wait writes
`timescale 1ns/10ps
`default_nettype none
`include "rwc_params.svh"

// How it works
// - return-jump with bits 29:25 nonzero is a bad encoding
// - return-jump, register form, bits 12:5 nonzero is a bad encoding
// - return-jump with no restorable window raises a fill trap
// - address mask clears the upper 32 target bits
// - return-jump target with low two bits nonzero is misaligned
// - allocate moves to a window whose ins are the old outs
// - a new window is clean: zeros or same-process values
// - untrapped allocate adds old-window sources into new rd
// - window pointer arithmetic wraps modulo the window count
// - allocate: pointer up, savable down, restorable up
// - no savable window: spill trap, vector select, pointer plus 2
// - allocate, register form, bits 12:5 nonzero is a bad encoding
// - no clean spare window: clean trap, handler pointer plus 1
// - spilled-ack: savable up, then restorable or other down
// - spilled-ack never traps on trap level or consistency
// - spilled-ack with bits 18:0 nonzero is a bad encoding
// - spilled-ack outside privileged modes is a privilege fault
// - spilled-ack decodes as secondary opcode 11 0001, function 0
// - return-jump releases a window, reading the old window
module rwc_core
  import rwc_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);

  localparam rwc_state_type RST = '{
    phase:  RWC_IDLE,
    addr:   '0,
    ctrl:   '0,
    win:    '{current_window_pointer: '0, savable_window_count: `RWC_RST_SAVE,
              restorable_window_count: '0, other_space_window_count: '0,
              clean_window_count: `RWC_RST_CLEAN},
    opa:    '0,
    opb:    '0,
    res:    '0,
    stat:   '{evt: RWC_EV_NONE, vother: 1'b0,
              vnum: '0, hcwp: '0, rd: '0,
              rdwe: 1'b0, done: 1'b0},
    hrdata: '0,
    hready: 1'b1,
    hresp:  1'b0
  };

  rwc_state_type      s_ff;
  rwc_state_type      nxt_s;

  logic [31:0]        ins;
  logic               imm;
  logic               fmt3;
  logic               is_alloc;
  logic               is_retj;
  logic               is_ack;
  logic               regjunk;
  logic [63:0]        opb_eff;
  logic [63:0]        sum;
  logic [63:0]        tgt;
  logic [`RWC_WW-1:0] clean_free;
  logic               vother;
  logic [2:0]         vnum;
  logic               exec;
  logic               accept;
  logic [31:0]        rword;

  // the instruction word arrives as write data on the issue register
  assign ins      = hwdata;
  assign imm      = ins[13];
  assign fmt3     = (ins[31:30] == `RWC_FMT3);
  assign is_alloc = fmt3 && (ins[24:19] == `RWC_OP3_ALLOC);
  assign is_retj  = fmt3 && (ins[24:19] == `RWC_OP3_RETJ);
  assign is_ack   = fmt3 && (ins[24:19] == `RWC_OP3_ACK)
                    && (ins[29:25] == 5'h00);
  assign regjunk  = !imm && (ins[12:5] != 8'h00);

  // opa and register-form opb come from the operand latches, i.e. the old window
  assign opb_eff  = imm ? {{51{ins[12]}}, ins[12:0]} : s_ff.opb;
  assign sum      = s_ff.opa + opb_eff;
  assign tgt      = s_ff.ctrl.am ? {32'h0000_0000, sum[31:0]}
                                 : sum;

  // unsigned wrap of a 3-bit field gives the modulo for free
  assign clean_free = s_ff.win.clean_window_count - s_ff.win.restorable_window_count;

  // vector selection shared by spill and fill traps
  assign vother = (s_ff.win.other_space_window_count != 3'h0);
  assign vnum   = vother ? s_ff.ctrl.window_trap_vector_select[5:3]
                         : s_ff.ctrl.window_trap_vector_select[2:0];

  assign exec   = (s_ff.phase == RWC_WR)
                  && (s_ff.addr == `RWC_OFF_INSTR);
  assign accept = hsel && hready && htrans[1];

  always_comb begin
    rword = 32'h0000_0000;
    case (s_ff.addr)
      `RWC_OFF_CTRL: begin
        rword[`RWC_CTRL_WINDOW_TRAP_VECTOR_SELECT +: 6] = s_ff.ctrl.window_trap_vector_select;
        rword[`RWC_CTRL_AM]          = s_ff.ctrl.am;
        rword[`RWC_CTRL_PRIV]        = s_ff.ctrl.priv;
        rword[`RWC_CTRL_HPRIV]       = s_ff.ctrl.hpriv;
        rword[`RWC_CTRL_TL +: 3]     = s_ff.ctrl.tl;
      end
      `RWC_OFF_WIN: begin
        rword[`RWC_WIN_CWP +: `RWC_WW]   = s_ff.win.current_window_pointer;
        rword[`RWC_WIN_SAVE +: `RWC_WW]  = s_ff.win.savable_window_count;
        rword[`RWC_WIN_REST +: `RWC_WW]  = s_ff.win.restorable_window_count;
        rword[`RWC_WIN_OTHER +: `RWC_WW] = s_ff.win.other_space_window_count;
        rword[`RWC_WIN_CLEAN +: `RWC_WW] = s_ff.win.clean_window_count;
      end
      `RWC_OFF_OPA_LO: rword = s_ff.opa[31:0];
      `RWC_OFF_OPA_HI: rword = s_ff.opa[63:32];
      `RWC_OFF_OPB_LO: rword = s_ff.opb[31:0];
      `RWC_OFF_OPB_HI: rword = s_ff.opb[63:32];
      `RWC_OFF_RES_LO: rword = s_ff.res[31:0];
      `RWC_OFF_RES_HI: rword = s_ff.res[63:32];
      `RWC_OFF_STATUS: begin
        rword[`RWC_ST_EVT +: 3]       = s_ff.stat.evt;
        rword[`RWC_ST_VOTHER]         = s_ff.stat.vother;
        rword[`RWC_ST_VNUM +: 3]      = s_ff.stat.vnum;
        rword[`RWC_ST_HCWP +: `RWC_WW] = s_ff.stat.hcwp;
        rword[`RWC_ST_RD +: 5]        = s_ff.stat.rd;
        rword[`RWC_ST_RDWE]           = s_ff.stat.rdwe;
        rword[`RWC_ST_DONE]           = s_ff.stat.done;
      end
      default: rword = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt_s        = s_ff;
    nxt_s.hresp  = 1'b0;
    nxt_s.hready = 1'b1;

    // bus phase tracking; reads take one wait state so that a read
    // right behind a write returns the freshly written value
    case (s_ff.phase)
      RWC_IDLE, RWC_WR: begin
        if (accept) begin
          nxt_s.addr   = haddr[`RWC_AW-1:0];
          nxt_s.phase  = hwrite ? RWC_WR : RWC_RD;
          nxt_s.hready = hwrite;
        end else begin
          nxt_s.phase  = RWC_IDLE;
        end
      end
      RWC_RD: begin
        nxt_s.hrdata = rword;
        nxt_s.phase  = RWC_IDLE;
      end
      default: nxt_s.phase = RWC_IDLE;
    endcase

    // register writes land at the end of the data phase
    if (s_ff.phase == RWC_WR) begin
      case (s_ff.addr)
        `RWC_OFF_CTRL: begin
          nxt_s.ctrl.window_trap_vector_select = hwdata[`RWC_CTRL_WINDOW_TRAP_VECTOR_SELECT +: 6];
          nxt_s.ctrl.am     = hwdata[`RWC_CTRL_AM];
          nxt_s.ctrl.priv   = hwdata[`RWC_CTRL_PRIV];
          nxt_s.ctrl.hpriv  = hwdata[`RWC_CTRL_HPRIV];
          nxt_s.ctrl.tl     = hwdata[`RWC_CTRL_TL +: 3];
        end
        `RWC_OFF_WIN: begin
          nxt_s.win.current_window_pointer        = hwdata[`RWC_WIN_CWP +: `RWC_WW];
          nxt_s.win.savable_window_count    = hwdata[`RWC_WIN_SAVE +: `RWC_WW];
          nxt_s.win.restorable_window_count = hwdata[`RWC_WIN_REST +: `RWC_WW];
          nxt_s.win.other_space_window_count   = hwdata[`RWC_WIN_OTHER +: `RWC_WW];
          nxt_s.win.clean_window_count   = hwdata[`RWC_WIN_CLEAN +: `RWC_WW];
        end
        `RWC_OFF_OPA_LO: nxt_s.opa[31:0]  = hwdata;
        `RWC_OFF_OPA_HI: nxt_s.opa[63:32] = hwdata;
        `RWC_OFF_OPB_LO: nxt_s.opb[31:0]  = hwdata;
        `RWC_OFF_OPB_HI: nxt_s.opb[63:32] = hwdata;
        default: ;
      endcase
    end

    // instruction issue: outcome replaces the previous status
    if (exec) begin
      nxt_s.stat.done   = 1'b1;
      nxt_s.stat.rdwe   = 1'b0;
      nxt_s.stat.rd     = ins[29:25];
      nxt_s.stat.evt    = RWC_EV_NONE;
      nxt_s.stat.vother = 1'b0;
      nxt_s.stat.vnum   = 3'h0;
      nxt_s.stat.hcwp   = s_ff.win.current_window_pointer;

      if (is_alloc) begin
        if (regjunk) begin
          nxt_s.stat.evt = RWC_EV_BADENC;
        end else if (s_ff.win.savable_window_count == 3'h0) begin
          nxt_s.stat.evt    = RWC_EV_SPILL;
          nxt_s.stat.vother = vother;
          nxt_s.stat.vnum   = vnum;
          nxt_s.stat.hcwp   = s_ff.win.current_window_pointer + 3'h2;
        end else if (clean_free == 3'h0) begin
          // a trap hands the window to the cleaner so no stale data
          // from another process is ever exposed
          nxt_s.stat.evt  = RWC_EV_CLEAN;
          nxt_s.stat.hcwp = s_ff.win.current_window_pointer + 3'h1;
        end else begin
          // the file overlaps windows, so the new ins are the old outs
          nxt_s.win.current_window_pointer        = s_ff.win.current_window_pointer + 3'h1;
          nxt_s.win.savable_window_count    = s_ff.win.savable_window_count - 3'h1;
          nxt_s.win.restorable_window_count = s_ff.win.restorable_window_count + 3'h1;
          nxt_s.stat.hcwp      = s_ff.win.current_window_pointer + 3'h1;
          nxt_s.res            = sum;
          nxt_s.stat.rdwe      = 1'b1;
        end
      end else if (is_retj) begin
        nxt_s.res = tgt;
        if (ins[29:25] != 5'h00) begin
          nxt_s.stat.evt = RWC_EV_BADENC;
        end else if (regjunk) begin
          nxt_s.stat.evt = RWC_EV_BADENC;
        end else if (tgt[1:0] != 2'b00) begin
          nxt_s.stat.evt = RWC_EV_MISALIGN;
        end else if (s_ff.win.restorable_window_count == 3'h0) begin
          nxt_s.stat.evt    = RWC_EV_FILL;
          nxt_s.stat.vother = vother;
          nxt_s.stat.vnum   = vnum;
          nxt_s.stat.hcwp   = s_ff.win.current_window_pointer - 3'h1;
        end else begin
          // pointer moves in this same edge, ahead of the delay slot
          nxt_s.win.current_window_pointer        = s_ff.win.current_window_pointer - 3'h1;
          nxt_s.win.savable_window_count    = s_ff.win.savable_window_count + 3'h1;
          nxt_s.win.restorable_window_count = s_ff.win.restorable_window_count - 3'h1;
          nxt_s.stat.hcwp      = s_ff.win.current_window_pointer - 3'h1;
        end
      end else if (is_ack) begin
        if (ins[18:0] != 19'h0_0000) begin
          nxt_s.stat.evt = RWC_EV_BADENC;
        end else if (!s_ff.ctrl.priv && !s_ff.ctrl.hpriv) begin
          nxt_s.stat.evt = RWC_EV_PRIV;
        end else begin
          // trap level and counter sanity are left to software
          nxt_s.win.savable_window_count = s_ff.win.savable_window_count + 3'h1;
          if (s_ff.win.other_space_window_count == 3'h0) begin
            nxt_s.win.restorable_window_count = s_ff.win.restorable_window_count - 3'h1;
          end else begin
            nxt_s.win.other_space_window_count = s_ff.win.other_space_window_count - 3'h1;
          end
        end
      end else begin
        nxt_s.stat.evt = RWC_EV_UNKNOWN;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff <= RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign hrdata    = s_ff.hrdata;
  assign hreadyout = s_ff.hready;
  assign hresp     = s_ff.hresp;

endmodule
`default_nettype wire

// File: tb/rwc_monitor.sv
// checker for rwc_core: follows bus writes and judges STATUS reads after bad encodings, acks, spill and clean traps
// assumes CTRL and WIN are written before every INSTR they govern
`timescale 1ns/10ps
`default_nettype none
`include "rwc_params.svh"
module rwc_monitor (
  // bus side of the core
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout
);
  logic        act_ff, wr_ff;
  logic [7:0]  a_ff;
  logic [31:0] ins_ff, ctl_ff, win_ff;
  wire         wdp = act_ff && wr_ff;
  // data phase of a STATUS read ends in this cycle
  wire st = act_ff && !wr_ff && a_ff == `RWC_OFF_STATUS && hreadyout;
  wire [2:0] ev = hrdata[2:0];
  wire [2:0] current_window_pointer = win_ff[2:0];
  wire [5:0] op3 = ins_ff[24:19];
  wire f3 = ins_ff[31:30] == `RWC_FMT3;
  wire alc = f3 && op3 == `RWC_OP3_ALLOC;
  wire rj = f3 && op3 == `RWC_OP3_RETJ;
  wire ack = f3 && op3 == `RWC_OP3_ACK && ins_ff[29:25] == 5'h00;
  wire regx = !ins_ff[13] && ins_ff[12:5] != 8'h00;
  wire ackok = ack && ins_ff[18:0] == 19'h0_0000;
  wire prv = ctl_ff[9] || ctl_ff[10];
  wire aok = alc && !regx;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_ff <= 1'b0;
      wr_ff  <= 1'b0;
      a_ff   <= 8'h00;
      ins_ff <= 32'h0000_0000;
      ctl_ff <= 32'h0000_0000;
      win_ff <= 32'h0000_0000;
    end else if (hready) begin
      act_ff <= hsel && htrans[1];
      wr_ff  <= hwrite;
      a_ff   <= haddr[7:0];
      if (wdp && a_ff == `RWC_OFF_INSTR) ins_ff <= hwdata;
      if (wdp && a_ff == `RWC_OFF_CTRL) ctl_ff <= hwdata;
      if (wdp && a_ff == `RWC_OFF_WIN) win_ff <= hwdata;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  rj_rd_a: assert property (st && rj && ins_ff[29:25] != 5'h00 |-> ev == 3'h1)
    else $error("return jump rd bits missed");
  rj_mid_a: assert property (st && rj && ins_ff[29:25] == 5'h00
    && regx |-> ev == 3'h1) else $error("return jump mid bits missed");
  alc_mid_a: assert property (st && alc && regx |-> ev == 3'h1)
    else $error("allocate mid bits missed");
  ack_low_a: assert property (st && ack && !ackok |-> ev == 3'h1)
    else $error("ack low bits missed");
  ack_priv_a: assert property (st && ackok && !prv |-> ev == 3'h2)
    else $error("ack privilege missed");
  ack_free_a: assert property (st && ackok && prv |-> ev == 3'h0)
    else $error("privileged ack trapped");
  spill_ptr_a: assert property (st && aok && win_ff[6:4] == 3'h0
    |-> ev == 3'h4 && hrdata[10:8] == current_window_pointer + 3'h2) else $error("spill");
  clean_ptr_a: assert property (st && aok && win_ff[6:4] != 3'h0
    && win_ff[18:16] == win_ff[10:8] |-> ev == 3'h5
    && hrdata[10:8] == current_window_pointer + 3'h1) else $error("clean trap");
  ack_fcn_a: assert property (st && f3 && op3 == `RWC_OP3_ACK
    && ins_ff[29:25] != 5'h00 |-> ev == 3'h7) else $error("ack fcn");
  cover property (st && ev == 3'h4);
  cover property (st && ev == 3'h5);
  cover property (st && ev == 3'h6);
  cover property (st && ackok && prv);
endmodule
bind rwc_core rwc_monitor u_mon (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout)
);
`default_nettype wire

// File: tb/rwc_pipe_model.sv
// pipeline-side model of rwc_core: the one bus master
// assumes the bus hready is the core's hreadyout
`timescale 1ns/10ps
`default_nettype none
module rwc_pipe_model (
  // clock and answers
  input  wire logic        hclk,
  input  wire logic [31:0] hrdata,
  input  wire logic        hreadyout,
  // requests
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  logic hung;
  int   idle;
  initial begin
    hung   = 1'b0;
    idle   = 0;
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // a stuck slave is flagged, never waited on for ever
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) hung = 1'b1;
  endtask
  // idle cycles let the bench act as a slow pipeline
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    repeat (idle) @(posedge hclk);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wr ? wd : ~hwdata;
    wait_rdy();
    rd = hrdata;
  endtask
endmodule
`default_nettype wire

// File: tb/test_register_window_control.sv
// bench for rwc_core: each scenario but t_reset issues instructions over the bus
// assumes rwc_pipe_model finishes one whole transfer per call
`timescale 1ns/10ps
`default_nettype none
`include "rwc_params.svh"
module test_register_window_control;
  localparam logic [31:0] z = 32'h0000_0000, pv = 32'h0000_0200;
  localparam logic [31:0] m_all = 32'hFFFF_FFFF, m_ev = 32'h0000_0007;
  localparam logic [31:0] m_tr = 32'h0000_0707, m_vec = 32'h0000_077F;
  localparam logic [31:0] m_ok = 32'h0007_F707, alc = 32'h8BE0_4002;
  localparam logic [31:0] ack = 32'h8188_0000, rj = 32'h81C8_6008;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd_w, ah_v, bl_v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          errors, comparisons;
  initial hclk = 1'b0;
  always #2 hclk = ~hclk;
  rwc_core DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp)
  );
  rwc_pipe_model u_pipe (
    .hclk(hclk), .hrdata(hrdata), .hreadyout(hreadyout), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata)
  );
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_pipe.xfer(1'b1, a, d, rd_w);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, m);
    u_pipe.xfer(1'b0, a, z, rd_w);
    cmp(rd_w & m, e);
    // the slave never signals an error response
    cmp({31'h0000_0000, hresp}, z);
  endtask
  task automatic run(input logic [31:0] c, wi, al, ins, se, sm, we);
    wr(`RWC_OFF_CTRL, c);
    wr(`RWC_OFF_WIN, wi);
    wr(`RWC_OFF_OPA_LO, al);
    wr(`RWC_OFF_OPA_HI, ah_v);
    wr(`RWC_OFF_OPB_LO, bl_v);
    wr(`RWC_OFF_OPB_HI, z);
    wr(`RWC_OFF_INSTR, ins);
    rdc(`RWC_OFF_STATUS, se, sm);
    rdc(`RWC_OFF_WIN, we, m_all);
  endtask
  task automatic t_reset();
    rdc(`RWC_OFF_CTRL, z, m_all);
    rdc(`RWC_OFF_WIN, 32'h0000_0060, m_all);
    wr(`RWC_OFF_STATUS, m_all);
    wr(8'h40, m_all);
    rdc(`RWC_OFF_STATUS, z, m_all);
    rdc(8'h40, z, m_all);
  endtask
  task automatic t_alloc();
    ah_v = 32'h0000_0001;
    run(pv, 32'h0007_0067, 32'hFFFF_FFF0, alc, 32'h0006_5000,
        m_ok, 32'h0007_0150);
    rdc(`RWC_OFF_RES_LO, 32'h0000_0010, m_all);
    rdc(`RWC_OFF_RES_HI, 32'h0000_0002, m_all);
    ah_v = z;
    run(pv, 32'h0007_0223, 32'h0000_0005, 32'h8DE0_7FFF,
        32'h0006_6400, m_ok, 32'h0007_0314);
    rdc(`RWC_OFF_RES_LO, 32'h0000_0004, m_all);
    rdc(`RWC_OFF_RES_HI, z, m_all);
  endtask
  task automatic t_alloc_trap();
    run(32'h0000_022A, 32'h0007_0405, z, alc, 32'h0000_0724,
        m_vec, 32'h0007_0405);
    run(32'h0000_022A, 32'h0007_2405, z, alc, 32'h0000_075C,
        m_vec, 32'h0007_2405);
    run(pv, 32'h0002_0231, z, alc, 32'h0000_0205, m_tr,
        32'h0002_0231);
    run(pv, z, z, 32'h8BE0_4022, 32'h0000_0001, m_ev, z);
  endtask
  task automatic t_ack();
    // every ack starts with savable below 6 and restorable above 0
    u_pipe.idle = 2;
    run(pv, 32'h0000_0230, z, ack, z, m_ev, 32'h0000_0140);
    run(pv, 32'h0000_1230, z, ack, z, m_ev, 32'h0000_0240);
    run(32'h0000_5400, 32'h0000_0312, z, ack, z, m_ev,
        32'h0000_0222);
    run(z, 32'h0000_0230, z, ack, 32'h0000_0002, m_ev,
        32'h0000_0230);
    run(pv, 32'h0000_0230, z, 32'h8188_0001, 32'h0000_0001,
        m_ev, 32'h0000_0230);
    run(pv, 32'h0000_0230, z, 32'h8388_0000, 32'h0000_0007,
        m_ev, 32'h0000_0230);
    u_pipe.idle = 0;
  endtask
  task automatic t_retj();
    ah_v = 32'hDEAD_BEEF;
    run(pv, 32'h0002_0230, 32'h0000_0100, rj, z, m_ev,
        32'h0002_0147);
    rdc(`RWC_OFF_RES_HI, 32'hDEAD_BEEF, m_all);
    run(32'h0000_0300, 32'h0002_0230, 32'h0000_0100, rj, z, m_ev,
        32'h0002_0147);
    rdc(`RWC_OFF_RES_LO, 32'h0000_0108, m_all);
    rdc(`RWC_OFF_RES_HI, z, m_all);
    run(pv, 32'h0002_0230, 32'h0000_0101, rj, 32'h0000_0003, m_ev,
        32'h0002_0230);
    run(pv, 32'h0002_0230, 32'h0000_0102, rj, 32'h0000_0003, m_ev,
        32'h0002_0230);
    run(pv, 32'h0002_0230, z, 32'h83C8_6008, 32'h0000_0001, m_ev,
        32'h0002_0230);
    run(pv, 32'h0002_0230, z, 32'h81C8_4202, 32'h0000_0001, m_ev,
        32'h0002_0230);
    run(pv, 32'h0000_0060, 32'h0000_0100, rj, 32'h0000_0706, m_tr,
        32'h0000_0060);
  endtask
  initial begin
    errors = 0;
    comparisons = 0;
    ah_v = z;
    bl_v = 32'h0000_0020;
    hresetn = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_alloc();
    t_alloc_trap();
    t_ack();
    t_retj();
    report_and_stop();
  end
  always @(posedge hclk) begin
    if (u_pipe.hung === 1'b1) begin
      errors++;
      report_and_stop();
    end
  end
endmodule
`default_nettype wire
